//--- inc/alarm_pkg.sv
// constants for the alarm code encoder
// assumes one 20 MHz clock and synchronous active-high reset
package alarm_pkg;
	// alarm display codes, low byte of the displayed code
	localparam logic [7:0] CODE_NONE     = 8'h00;
	localparam logic [7:0] CODE_POS_OVF  = 8'hD0;
	localparam logic [7:0] CODE_NO_MOD   = 8'hE0;
	localparam logic [7:0] CODE_MOD_TO   = 8'hE1;
	localparam logic [7:0] CODE_MOD_WD   = 8'hE2;
	localparam logic [7:0] CODE_DUP_ADDR = 8'hE6;
	localparam logic [7:0] CODE_MOD_DET  = 8'hE7;
	localparam logic [7:0] CODE_SWITCH   = 8'hE8;
	localparam logic [7:0] CODE_BUS_OFF  = 8'hE9;
	localparam logic [7:0] CODE_INIT_ACC = 8'hEB;
	localparam logic [7:0] CODE_AMP_WD   = 8'hEC;
	// switch limits
	localparam logic [3:0] BAUD_MAX      = 4'h2;
	localparam logic [6:0] NODE_MAX      = 7'h3F;
	// output levels: 1 = transistor on
	localparam logic       XSTR_ON       = 1'b1;
	localparam logic       XSTR_OFF      = 1'b0;
	// reset values
	localparam logic [7:0] CODE_RESET    = 8'h00;
	localparam logic [3:0] OUT_RESET     = 4'h1;
	localparam logic [1:0] SETTLE_RESET  = 2'h0;
	// edges after release before presence is sampled through the synchroniser
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;
	// amplifier watchdog output pattern, code bits 1..3 then summary
	localparam logic [3:0] PAT_AMP_WD    = 4'h6;
endpackage : alarm_pkg

//--- verilog/sync2.sv
// two flip-flop synchroniser, one per bit
// assumes the inputs are asynchronous to ref_clk
`timescale 1ns/1ns
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule : sync2

//--- verilog/alarm_encoder.sv
// alarm detection and open-collector code output encoder
// assumes fault inputs arrive from outside the clock domain
`timescale 1ns/1ns
// What this block does
// - summary output alarm level is transistor off; non-alarm level is transistor on
// - position error overflow gives code bits one,two on, three off, summary off
// - missing module gives bit one off, two and three on, summary off
// - module timeout gives bit one off, two and three on, summary off
// - module watchdog fault gives bit one off, two and three on, summary off
// - duplicate node address gives bit one off, two and three on
// - module missing at power-on after earlier use latches until removal acknowledge
// - baud selector above two raises switch setting alarm
// - node address selector above 63 raises switch setting alarm
// - bus-off gives bit one off, two and three on, summary off
// - initial access failure gives bit one off, two and three on, summary off
// - amplifier watchdog check failure gives bit one off, two and three on, summary off, with its own display code
// - no alarm drives all code bits off and summary on
module alarm_encoder (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       position_error_overflow,
	input  wire logic       module_present,
	input  wire logic       module_previously_installed,
	input  wire logic       module_timeout,
	input  wire logic       module_watchdog_fault,
	input  wire logic       duplicate_address,
	input  wire logic [3:0] baud_rate_switch,
	input  wire logic [6:0] node_address_switch,
	input  wire logic       bus_off,
	input  wire logic       initial_access_fail,
	input  wire logic       watchdog_counter_check_fail,
	input  wire logic       module_removal_acknowledge_function,
	output logic            alarm_code_bit_one,
	output logic            alarm_code_bit_two,
	output logic            alarm_code_bit_three,
	output logic            summary_alarm_output,
	output logic            alarm_active,
	output logic [7:0]      alarm_code
);
	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	// switch values are static, so per-bit synchronising is safe
	localparam int NSYNC = 21;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] syn;

	assign raw_in = {position_error_overflow, module_present, module_previously_installed,
		module_timeout, module_watchdog_fault, duplicate_address, baud_rate_switch,
		node_address_switch, bus_off, initial_access_fail, watchdog_counter_check_fail,
		module_removal_acknowledge_function};

	sync2 #(.WIDTH(NSYNC)) u_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in (raw_in),
		.sync_out (syn)
	);

	logic       s_pos_ovf;
	logic       s_present;
	logic       s_prev;
	logic       s_mod_to;
	logic       s_mod_wd;
	logic       s_dup;
	logic [3:0] s_baud;
	logic [6:0] s_node;
	logic       s_bus_off;
	logic       s_init;
	logic       s_amp_wd;
	logic       s_ack;

	assign {s_pos_ovf, s_present, s_prev, s_mod_to, s_mod_wd, s_dup, s_baud,
		s_node, s_bus_off, s_init, s_amp_wd, s_ack} = syn;

	////////////////////////////////////////////////////////////////////////
	// front-panel switch range check
	logic baud_bad;
	logic node_bad;

	always_comb begin
		baud_bad = (s_baud > alarm_pkg::BAUD_MAX);
		node_bad = (s_node > alarm_pkg::NODE_MAX);
	end

	////////////////////////////////////////////////////////////////////////
	// module lost since earlier use
	logic module_lost;

	always_comb begin
		module_lost = !s_present && s_prev;
	end

	////////////////////////////////////////////////////////////////////////
	// power-on check and alarm latch
	typedef enum logic [2:0] {
		ST_START   = 3'b001,
		ST_RUN     = 3'b010,
		ST_DET_ERR = 3'b100
	} state_t;

	state_t     state_reg;
	state_t     state_next;
	logic [1:0] settle_reg;
	logic [1:0] settle_next;
	logic [7:0] code_reg;
	logic [7:0] code_next;
	logic [3:0] out_reg;
	logic [3:0] out_next;
	logic [7:0] new_code;
	logic [3:0] new_pat;

	// priority encoder of live faults
	always_comb begin
		new_code = alarm_pkg::CODE_NONE;
		new_pat  = {alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_OFF,
			alarm_pkg::XSTR_ON};
		if (s_pos_ovf) begin
			new_code = alarm_pkg::CODE_POS_OVF;
			new_pat  = {alarm_pkg::XSTR_ON, alarm_pkg::XSTR_ON, alarm_pkg::XSTR_OFF,
				alarm_pkg::XSTR_OFF};
		end else if (!s_present) begin
			new_code = alarm_pkg::CODE_NO_MOD;
		end else if (s_mod_to) begin
			new_code = alarm_pkg::CODE_MOD_TO;
		end else if (s_mod_wd) begin
			new_code = alarm_pkg::CODE_MOD_WD;
		end else if (s_dup) begin
			new_code = alarm_pkg::CODE_DUP_ADDR;
		end else if (baud_bad) begin
			new_code = alarm_pkg::CODE_SWITCH;
		end else if (node_bad) begin
			new_code = alarm_pkg::CODE_SWITCH;
		end else if (s_bus_off) begin
			new_code = alarm_pkg::CODE_BUS_OFF;
		end else if (s_init) begin
			new_code = alarm_pkg::CODE_INIT_ACC;
		end else if (s_amp_wd) begin
			new_code = alarm_pkg::CODE_AMP_WD;
			new_pat  = alarm_pkg::PAT_AMP_WD;
		end
		if (new_code != alarm_pkg::CODE_NONE && new_code != alarm_pkg::CODE_POS_OVF &&
			new_code != alarm_pkg::CODE_AMP_WD) begin
			new_pat = {alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_ON, alarm_pkg::XSTR_ON,
				alarm_pkg::XSTR_OFF};
		end
	end

	always_comb begin
		state_next  = state_reg;
		settle_next = settle_reg;
		code_next   = code_reg;
		out_next    = out_reg;
		case (state_reg)
			ST_START: begin
				// both synchroniser stages must fill before presence is trusted
				if (settle_reg != alarm_pkg::SETTLE_CYCLES) begin
					settle_next = settle_reg + 2'h1;
				end else if (module_lost) begin
					state_next = ST_DET_ERR;
					code_next  = alarm_pkg::CODE_MOD_DET;
					out_next   = {alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_ON,
						alarm_pkg::XSTR_ON, alarm_pkg::XSTR_OFF};
				end else begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (code_reg == alarm_pkg::CODE_NONE) begin
					code_next = new_code;
					out_next  = new_pat;
				end
			end
			ST_DET_ERR: begin
				if (s_ack) begin
					state_next = ST_RUN;
					code_next  = alarm_pkg::CODE_NONE;
					out_next   = alarm_pkg::OUT_RESET & {alarm_pkg::XSTR_OFF,
						alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_OFF, alarm_pkg::XSTR_ON};
				end
			end
			default: begin
				state_next = ST_START;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg  <= ST_START;
			settle_reg <= alarm_pkg::SETTLE_RESET;
			code_reg   <= alarm_pkg::CODE_RESET;
			out_reg    <= alarm_pkg::OUT_RESET;
		end else begin
			state_reg  <= state_next;
			settle_reg <= settle_next;
			code_reg   <= code_next;
			out_reg    <= out_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	logic active_reg;
	logic active_next;

	// tracks the latched code on the same edge
	always_comb begin
		active_next = (code_next != alarm_pkg::CODE_NONE);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
		end
	end

	assign alarm_code_bit_one   = out_reg[3];
	assign alarm_code_bit_two   = out_reg[2];
	assign alarm_code_bit_three = out_reg[1];
	assign summary_alarm_output = out_reg[0];
	assign alarm_active         = active_reg;
	assign alarm_code           = code_reg;
endmodule : alarm_encoder

//--- verif/alarm_encoder_monitor.sv
// port checker for the alarm encoder
// assumes a bind onto alarm_encoder
`timescale 1ns/1ns
module alarm_encoder_monitor (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       position_error_overflow,
	input wire logic [3:0] baud_rate_switch,
	input wire logic       module_removal_acknowledge_function,
	input wire logic       alarm_code_bit_one,
	input wire logic       alarm_code_bit_two,
	input wire logic       alarm_code_bit_three,
	input wire logic       summary_alarm_output,
	input wire logic       alarm_active,
	input wire logic [7:0] alarm_code
);
	logic [3:0] pat;
	logic       ack;
	assign pat = {alarm_code_bit_one, alarm_code_bit_two, alarm_code_bit_three,
		summary_alarm_output};
	assign ack = module_removal_acknowledge_function;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_idle; !alarm_active |-> pat == 4'h1; endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_d0; alarm_code == 8'hD0 |-> pat == 4'hC; endproperty
	a_d0: assert property (p_d0) else $error("overflow level");
	property p_egrp; alarm_code[7:4] == 4'hE |-> pat == 4'h6; endproperty
	a_egrp: assert property (p_egrp) else $error("module level");
	property p_sum; summary_alarm_output == !alarm_active; endproperty
	a_sum: assert property (p_sum) else $error("summary level");
	property p_hold; alarm_active && alarm_code != 8'hE7 |=> $stable(alarm_code); endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_act; alarm_active == (alarm_code != 8'h00); endproperty
	a_act: assert property (p_act) else $error("active flag");
	property p_ovf; (position_error_overflow && !ack)[*6] |-> alarm_active; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	property p_baud; (baud_rate_switch > 4'h2 && !ack)[*6] |-> alarm_active; endproperty
	a_baud: assert property (p_baud) else $error("baud missed");
endmodule : alarm_encoder_monitor
bind alarm_encoder alarm_encoder_monitor i_alarm_encoder_monitor (.ref_clk, .reset,
	.position_error_overflow, .baud_rate_switch, .module_removal_acknowledge_function,
	.alarm_code_bit_one, .alarm_code_bit_two, .alarm_code_bit_three,
	.summary_alarm_output, .alarm_active, .alarm_code);

//--- verif/alarm_host_model.sv
// host view of the alarm outputs
// assumes outputs wired straight in
`timescale 1ns/1ns
module alarm_host_model (
	input wire logic  code_one,
	input wire logic  code_two,
	input wire logic  code_three,
	input wire logic  summary_in,
	output logic [3:0] seen_pattern
);
	assign seen_pattern = {code_one, code_two, code_three, summary_in};
endmodule : alarm_host_model

//--- verif/tb_alarm_encoder.sv
// self-checking bench for the alarm encoder
// assumes 20 MHz clock, synchronous reset
`timescale 1ns/1ns
module tb_alarm_encoder;
	typedef struct packed {logic [20:0] in; logic [7:0] code; logic [3:0] pat;} row_t;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [20:0] stim = 21'h0C0000;
	logic        b1, b2, b3, sm;
	logic        act;
	logic [7:0]  code;
	logic [3:0]  seen;
	int          n_mismatch = 0;
	int          checks_done = 0;
	row_t rows [13] = '{'{21'h0C0000, 8'h00, 4'h1}, '{21'h1C0000, 8'hD0, 4'hC},
		'{21'h000000, 8'hE0, 4'h6}, '{21'h0E0000, 8'hE1, 4'h6}, '{21'h0D0000, 8'hE2, 4'h6},
		'{21'h0C8000, 8'hE6, 4'h6}, '{21'h040000, 8'hE7, 4'h6}, '{21'h0C1800, 8'hE8, 4'h6},
		'{21'h0C0400, 8'hE8, 4'h6}, '{21'h0C0008, 8'hE9, 4'h6}, '{21'h0C0004, 8'hEB, 4'h6},
		'{21'h0C0002, 8'hEC, 4'h6}, '{21'h0C13F0, 8'h00, 4'h1}};
	always #25 ref_clk = ~ref_clk;
	alarm_encoder i_alarm_encoder (.ref_clk(ref_clk), .reset(reset),
		.position_error_overflow(stim[20]), .module_present(stim[19]),
		.module_previously_installed(stim[18]), .module_timeout(stim[17]),
		.module_watchdog_fault(stim[16]), .duplicate_address(stim[15]),
		.baud_rate_switch(stim[14:11]), .node_address_switch(stim[10:4]),
		.bus_off(stim[3]), .initial_access_fail(stim[2]),
		.watchdog_counter_check_fail(stim[1]), .module_removal_acknowledge_function(stim[0]),
		.alarm_code_bit_one(b1), .alarm_code_bit_two(b2), .alarm_code_bit_three(b3),
		.summary_alarm_output(sm), .alarm_active(act), .alarm_code(code));
	alarm_host_model i_alarm_host_model (.code_one(b1), .code_two(b2), .code_three(b3),
		.summary_in(sm), .seen_pattern(seen));
	////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic restart(input logic [20:0] v);
		reset = 1'b1;
		stim = v;
		cyc(5);
		reset = 1'b0;
		cyc(10);
	endtask : restart
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		int k;
		foreach (rows[i]) begin
			restart(rows[i].in);
			check(code, rows[i].code);
			check({4'h0, seen}, {4'h0, rows[i].pat});
			check({7'h0, act}, {7'h0, (rows[i].code != 8'h00)});
		end
		restart(21'h1C0008);
		stim = 21'h0C0008;
		cyc(10);
		check(code, 8'hD0);
		reset = 1'b1;
		cyc(1);
		check({4'h0, seen}, 8'h01);
		check(code, 8'h00);
		check({7'h0, act}, 8'h00);
		reset = 1'b0;
		cyc(10);
		check(code, 8'hE9);
		restart(21'h040000);
		cyc(20);
		check(code, 8'hE7);
		stim = 21'h040001;
		for (k = 0; k < 20 && code === 8'hE7; k++) cyc(1);
		if (k == 20) n_mismatch++;
		else begin
			stim = 21'h040000;
			cyc(10);
			check(code, 8'hE0);
		end
		tally_and_finish();
	end
endmodule : tb_alarm_encoder
